// *** rtl/sct_regs.sv ***
// sdram configuration, timing and control register bank with decoded timing outputs
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module sct_regs #(
    parameter int AW = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    // sequencer side
    input wire logic init_done,
    input wire logic mode_upd_done,
    input wire logic self_ref_active,
    input wire logic refresh_ack,
    output logic init_req,
    output logic mode_upd_req,
    output logic self_ref_req,
    output logic pwr_dn_req,
    output logic delayed_pre,
    output logic refresh_req,
    output logic [4:0] col_bits,
    output logic [4:0] row_bits,
    output logic [2:0] bank_bits,
    output logic geom_err,
    output logic [5:0] data_width,
    output logic [4:0] t_rc,
    output logic [9:0] t_xsr,
    output logic [4:0] t_rcar,
    output logic [2:0] t_wr,
    output logic [3:0] t_rp,
    output logic [3:0] t_rcd,
    output logic [4:0] t_ras,
    output logic [2:0] rd_latency,
    output logic lat_err,
    output logic [4:0] init_refreshes,
    output logic [15:0] pwrup_cycles
);
    logic rst_s1_q, rst_s2_q;
    logic [31:0] geom_q, tim_a_q, tim_b_q, ctrl_q, refi_q;
    logic [31:0] misc_q [12];
    logic [15:0] ref_cnt_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_d;
    logic wr_geom, wr_tim_a, wr_tim_b, wr_ctrl, wr_refi;
    logic [2:0] cas_code;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // write decode; every access is a whole word
    assign wr_geom = wr_stb && clk_en && addr == AW'(sct_pkg::SCT_OFF_GEOM); // R15
    assign wr_tim_a = wr_stb && clk_en && addr == AW'(sct_pkg::SCT_OFF_TIM_A);
    assign wr_tim_b = wr_stb && clk_en && addr == AW'(sct_pkg::SCT_OFF_TIM_B);
    assign wr_ctrl = wr_stb && clk_en && addr == AW'(sct_pkg::SCT_OFF_CTRL);
    assign wr_refi = wr_stb && clk_en && addr == AW'(sct_pkg::SCT_OFF_REFI);

    // geometry and timing registers; new values steer later commands and the next init
    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            geom_q <= sct_pkg::SCT_RST_GEOM;
            tim_a_q <= sct_pkg::SCT_RST_TIM_A;
            tim_b_q <= sct_pkg::SCT_RST_TIM_B;
            refi_q <= sct_pkg::SCT_RST_REFI;
        end else begin
            if (wr_geom) begin
                geom_q <= wdata & sct_pkg::SCT_WM_GEOM; // R19
            end
            if (wr_tim_a) begin
                tim_a_q <= wdata & sct_pkg::SCT_WM_TIM_A; // R19
            end
            if (wr_tim_b) begin
                tim_b_q <= wdata & sct_pkg::SCT_WM_TIM_B;
            end
            if (wr_refi) begin
                refi_q <= wdata & sct_pkg::SCT_WM_REFI;
            end
        end
    end

    // control register; self-clearing bits, a software set wins over the hardware clear
    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            ctrl_q <= sct_pkg::SCT_RST_CTRL; // R16
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_q[31:12] <= wdata[31:12] & sct_pkg::SCT_WM_CTRL[31:12];
                ctrl_q[10:0] <= wdata[10:0] & sct_pkg::SCT_WM_CTRL[10:0];
            end
            if (init_done && !(wr_ctrl && wdata[sct_pkg::SCT_INIT_BIT])) begin
                ctrl_q[sct_pkg::SCT_INIT_BIT] <= 1'b0; // R16
            end
            if (mode_upd_done && !(wr_ctrl && wdata[sct_pkg::SCT_MODE_UPD_BIT])) begin
                ctrl_q[sct_pkg::SCT_MODE_UPD_BIT] <= 1'b0; // R17
            end
            ctrl_q[sct_pkg::SCT_SR_STAT_BIT] <= self_ref_active;
        end
    end

    // chip select, mask, remap and static timing registers, stored only
    localparam logic [7:0] MISC_OFF [12] = '{sct_pkg::SCT_OFF_CSB0, sct_pkg::SCT_OFF_CSB1,
        sct_pkg::SCT_OFF_CSB2, sct_pkg::SCT_OFF_MSK0, sct_pkg::SCT_OFF_MSK1, sct_pkg::SCT_OFF_MSK2,
        sct_pkg::SCT_OFF_REMAP0, sct_pkg::SCT_OFF_STM0, sct_pkg::SCT_OFF_STM1, sct_pkg::SCT_OFF_STM2,
        sct_pkg::SCT_OFF_FLPD, sct_pkg::SCT_OFF_SCTL};
    localparam logic [31:0] MISC_RST [12] = '{sct_pkg::SCT_RST_CSB0, sct_pkg::SCT_RST_CSB1,
        sct_pkg::SCT_RST_CSB2, sct_pkg::SCT_RST_MSK0, sct_pkg::SCT_RST_MSK1, sct_pkg::SCT_RST_MSK2,
        sct_pkg::SCT_RST_REMAP0, sct_pkg::SCT_RST_STM0, sct_pkg::SCT_RST_STM1, sct_pkg::SCT_RST_STM2,
        sct_pkg::SCT_RST_FLPD, sct_pkg::SCT_RST_SCTL};
    localparam logic [31:0] MISC_WM [12] = '{sct_pkg::SCT_WM_HI16, sct_pkg::SCT_WM_HI16,
        sct_pkg::SCT_WM_HI16, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff};
    generate
        for (genvar i = 0; i < 12; i++) begin : g_misc
            always_ff @(posedge ref_clk or negedge rst_s2_q) begin
                if (!rst_s2_q) begin
                    misc_q[i] <= MISC_RST[i];
                end else if (wr_stb && clk_en && addr == AW'(MISC_OFF[i])) begin
                    misc_q[i] <= wdata & MISC_WM[i];
                end
            end
        end
    endgenerate

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_d = 32'h0;
        case (addr)
            AW'(sct_pkg::SCT_OFF_GEOM): rd_d = geom_q;
            AW'(sct_pkg::SCT_OFF_TIM_A): rd_d = tim_a_q;
            AW'(sct_pkg::SCT_OFF_TIM_B): rd_d = tim_b_q;
            AW'(sct_pkg::SCT_OFF_CTRL): rd_d = ctrl_q;
            AW'(sct_pkg::SCT_OFF_REFI): rd_d = refi_q;
            default: begin
                for (int i = 0; i < 12; i++) begin
                    if (addr == AW'(MISC_OFF[i])) begin
                        rd_d = misc_q[i];
                    end
                end
            end
        endcase
    end

    // read data registered, valid the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            rdata_q <= 32'h0;
        end else if (clk_en && rd_stb) begin
            rdata_q <= rd_d;
        end
    end
    assign rdata = rdata_q;

    // refresh interval counter, request held until acknowledged
    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            ref_cnt_q <= 16'h0;
            refresh_req <= 1'b0;
        end else if (clk_en) begin
            if (ref_cnt_q >= refi_q[15:0] - 16'h1) begin
                ref_cnt_q <= 16'h0;
                refresh_req <= 1'b1; // R18
            end else begin
                ref_cnt_q <= ref_cnt_q + 16'h1;
                if (refresh_ack) begin
                    refresh_req <= 1'b0;
                end
            end
        end
    end

    // control outputs
    assign init_req = ctrl_q[sct_pkg::SCT_INIT_BIT]; // R16
    assign mode_upd_req = ctrl_q[sct_pkg::SCT_MODE_UPD_BIT]; // R17
    assign self_ref_req = ctrl_q[sct_pkg::SCT_SELF_REF_BIT];
    assign pwr_dn_req = ctrl_q[sct_pkg::SCT_PWR_DN_BIT];
    assign delayed_pre = ctrl_q[sct_pkg::SCT_DLY_PRE_BIT];

    // geometry decode: codes are bit counts minus one
    assign col_bits = {1'b0, geom_q[sct_pkg::SCT_COL_LSB +: 4]} + 5'h1; // R1
    assign row_bits = {1'b0, geom_q[sct_pkg::SCT_ROW_LSB +: 4]} + 5'h1; // R2
    assign bank_bits = {1'b0, geom_q[sct_pkg::SCT_BANK_LSB +: 2]} + 3'h1; // R3
    assign geom_err = geom_q[sct_pkg::SCT_COL_LSB +: 4] < sct_pkg::SCT_COL_MIN
        || geom_q[sct_pkg::SCT_COL_LSB +: 4] > sct_pkg::SCT_COL_MAX // R1
        || geom_q[sct_pkg::SCT_ROW_LSB +: 4] < sct_pkg::SCT_ROW_MIN; // R2
    assign data_width = sct_pkg::SCT_DATA_WIDTH; // R4

    // timing decode: each code stands for code plus one clocks or refreshes; pwrup_cycles is taken as is
    assign t_rc = {1'b0, tim_a_q[sct_pkg::SCT_TRC_LSB +: 4]} + 5'h1; // R5
    assign t_xsr = {1'b0, tim_a_q[sct_pkg::SCT_TXSR_HI_LSB +: 5],
        tim_a_q[sct_pkg::SCT_TXSR_LO_LSB +: 4]} + 10'h1; // R6
    assign t_rcar = {1'b0, tim_a_q[sct_pkg::SCT_TRCAR_LSB +: 4]} + 5'h1; // R7
    assign t_wr = {1'b0, tim_a_q[sct_pkg::SCT_TWR_LSB +: 2]} + 3'h1; // R8
    assign t_rp = {1'b0, tim_a_q[sct_pkg::SCT_TRP_LSB +: 3]} + 4'h1; // R9
    assign t_rcd = {1'b0, tim_a_q[sct_pkg::SCT_TRCD_LSB +: 3]} + 4'h1; // R10
    assign t_ras = {1'b0, tim_a_q[sct_pkg::SCT_TRAS_LSB +: 4]} + 5'h1; // R11
    assign cas_code = {tim_a_q[sct_pkg::SCT_CAS_HI_BIT], tim_a_q[sct_pkg::SCT_CAS_LO_LSB +: 2]};
    assign rd_latency = cas_code + 3'h1; // R12
    assign lat_err = cas_code > sct_pkg::SCT_CAS_MAX; // R12
    assign init_refreshes = {1'b0, tim_b_q[sct_pkg::SCT_NINIT_REF_LSB +: 4]} + 5'h1; // R13
    assign pwrup_cycles = tim_b_q[sct_pkg::SCT_PWRUP_LSB +: 16]; // R14
endmodule

// *** rtl/sct_pkg.sv ***
// package: register map, field layout, reset values and timing constants of the sdram config bank
// What this block does
// R1 - column width field codes 7..14 give 8..15 column bits; others reserved
// R2 - row width field codes 10..15 give 11..16 row bits; lower codes reserved
// R3 - bank width field codes 0..3 give 1..4 bank bits
// R4 - data width field is stored but ignored; data bus stays 32 bits
// R5 - active to active spacing t_rc, code plus one clocks
// R6 - self-refresh exit wait t_xsr, split field, code plus one clocks
// R7 - auto-refresh to auto-refresh spacing t_rcar, code plus one clocks
// R8 - last write data to precharge t_wr, code plus one clocks
// R9 - precharge to next command t_rp, code plus one clocks
// R10 - active to read or write t_rcd, code plus one clocks
// R11 - active to precharge minimum t_ras, code plus one clocks
// R12 - read latency split field, codes 0..3 give 1..4 clocks, rest reserved
// R13 - initialization issues code plus one auto-refreshes
// R14 - after power up hold inputs stable the programmed cycle count
// R15 - software uses only full word accesses
// R16 - initialize bit starts init, self-clears at end, resets to one
// R17 - mode update bit rewrites mode register, self-clears when done
// R18 - refresh request every programmed interval, reset 0x410
// R19 - written values apply to later commands and the next init
package sct_pkg;
    localparam logic [7:0] SCT_OFF_GEOM = 8'h00;
    localparam logic [7:0] SCT_OFF_TIM_A = 8'h04;
    localparam logic [7:0] SCT_OFF_TIM_B = 8'h08;
    localparam logic [7:0] SCT_OFF_CTRL = 8'h0c;
    localparam logic [7:0] SCT_OFF_REFI = 8'h10;
    localparam logic [7:0] SCT_OFF_CSB0 = 8'h14;
    localparam logic [7:0] SCT_OFF_CSB1 = 8'h18;
    localparam logic [7:0] SCT_OFF_CSB2 = 8'h1c;
    localparam logic [7:0] SCT_OFF_MSK0 = 8'h54;
    localparam logic [7:0] SCT_OFF_MSK1 = 8'h58;
    localparam logic [7:0] SCT_OFF_MSK2 = 8'h5c;
    localparam logic [7:0] SCT_OFF_REMAP0 = 8'h84;
    localparam logic [7:0] SCT_OFF_STM0 = 8'h94;
    localparam logic [7:0] SCT_OFF_STM1 = 8'h98;
    localparam logic [7:0] SCT_OFF_STM2 = 8'h9c;
    localparam logic [7:0] SCT_OFF_FLPD = 8'ha0;
    localparam logic [7:0] SCT_OFF_SCTL = 8'ha4;

    localparam logic [31:0] SCT_RST_GEOM = 32'h001c4f68;
    localparam logic [31:0] SCT_RST_TIM_A = 32'h01e5d696;
    localparam logic [31:0] SCT_RST_TIM_B = 32'h00007008;
    localparam logic [31:0] SCT_RST_CTRL = 32'h00003009;
    localparam logic [31:0] SCT_RST_REFI = 32'h00000410;
    localparam logic [31:0] SCT_RST_CSB0 = 32'h00000000;
    localparam logic [31:0] SCT_RST_CSB1 = 32'h00005100;
    localparam logic [31:0] SCT_RST_CSB2 = 32'h00006000;
    localparam logic [31:0] SCT_RST_MSK0 = 32'h00000149;
    localparam logic [31:0] SCT_RST_MSK1 = 32'h00000249;
    localparam logic [31:0] SCT_RST_MSK2 = 32'h0000000c;
    localparam logic [31:0] SCT_RST_REMAP0 = 32'h50000000;
    localparam logic [31:0] SCT_RST_STM0 = 32'h0001154c;
    localparam logic [31:0] SCT_RST_STM1 = 32'h00791950;
    localparam logic [31:0] SCT_RST_STM2 = 32'h001c1950;
    localparam logic [31:0] SCT_RST_FLPD = 32'h000000c8;
    localparam logic [31:0] SCT_RST_SCTL = 32'h00001201;

    // writable bits of each register; the rest read zero after a write, except control bit 11, which reads self-refresh status
    localparam logic [31:0] SCT_WM_GEOM = 32'h001ffff8;
    localparam logic [31:0] SCT_WM_TIM_A = 32'hffffffff;
    localparam logic [31:0] SCT_WM_TIM_B = 32'h003fffff;
    localparam logic [31:0] SCT_WM_CTRL = 32'h0003f3ff;
    localparam logic [31:0] SCT_WM_REFI = 32'h00ffffff;
    localparam logic [31:0] SCT_WM_HI16 = 32'hffff0000;

    // geometry fields
    localparam int SCT_COL_LSB = 9;
    localparam int SCT_ROW_LSB = 5;
    localparam int SCT_BANK_LSB = 3;
    localparam int SCT_DW_LSB = 13;
    // timing a fields
    localparam int SCT_TRC_LSB = 22;
    localparam int SCT_TXSR_HI_LSB = 27;
    localparam int SCT_TXSR_LO_LSB = 18;
    localparam int SCT_TRCAR_LSB = 14;
    localparam int SCT_TWR_LSB = 12;
    localparam int SCT_TRP_LSB = 9;
    localparam int SCT_TRCD_LSB = 6;
    localparam int SCT_TRAS_LSB = 2;
    localparam int SCT_CAS_HI_BIT = 26;
    localparam int SCT_CAS_LO_LSB = 0;
    // timing b fields
    localparam int SCT_NINIT_REF_LSB = 16;
    localparam int SCT_PWRUP_LSB = 0;
    // control fields
    localparam int SCT_INIT_BIT = 0;
    localparam int SCT_SELF_REF_BIT = 1;
    localparam int SCT_PWR_DN_BIT = 2;
    localparam int SCT_DLY_PRE_BIT = 3;
    localparam int SCT_MODE_UPD_BIT = 9;
    localparam int SCT_SR_STAT_BIT = 11;

    // limits of the legal codes and the fixed data width
    localparam logic [3:0] SCT_COL_MIN = 4'h7;
    localparam logic [3:0] SCT_COL_MAX = 4'he;
    localparam logic [3:0] SCT_ROW_MIN = 4'ha;
    localparam logic [2:0] SCT_CAS_MAX = 3'h3;
    localparam logic [5:0] SCT_DATA_WIDTH = 6'h20;
    // mode register set clock count, used nowhere; the mode bit clears on mode_upd_done
    localparam logic [3:0] SCT_MRS_CYCLES = 4'h2;
endpackage

// *** verification/sct_regs_checker.sv ***
// assertion checker for the sdram config register bank, bound to its ports
`timescale 1ns/1ps
module sct_regs_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic init_done,
    input wire logic mode_upd_done,
    input wire logic refresh_ack,
    input wire logic init_req,
    input wire logic mode_upd_req,
    input wire logic refresh_req,
    input wire logic [4:0] col_bits,
    input wire logic [4:0] row_bits,
    input wire logic [2:0] bank_bits,
    input wire logic geom_err,
    input wire logic [5:0] data_width,
    input wire logic [4:0] t_rc,
    input wire logic [9:0] t_xsr,
    input wire logic [4:0] t_rcar,
    input wire logic [2:0] t_wr,
    input wire logic [3:0] t_rp,
    input wire logic [3:0] t_rcd,
    input wire logic [4:0] t_ras,
    input wire logic [2:0] rd_latency,
    input wire logic lat_err,
    input wire logic [4:0] init_refreshes,
    input wire logic [15:0] pwrup_cycles
);
    // decoded register writes
    wire wg = wr_stb && clk_en && addr == 8'h00;
    wire wa = wr_stb && clk_en && addr == 8'h04;
    wire wb = wr_stb && clk_en && addr == 8'h08;
    wire wc = wr_stb && clk_en && addr == 8'h0c;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // control writes that set the init or the mode bit
    sequence s_init_set;
        wc && wdata[0];
    endsequence
    sequence s_mode_set;
        wc && wdata[9];
    endsequence
    AST_COL: assert property (wg |=> col_bits == $past(wdata[12:9]) + 5'h1)
        else $error("column width wrong");
    AST_GEOM_ERR: assert property (wg |=> geom_err == ($past(wdata[12:9]) < 4'h7 ||
        $past(wdata[12:9]) == 4'hf || $past(wdata[8:5]) < 4'ha)) else $error("geometry error flag wrong");
    AST_ROW: assert property (wg |=> row_bits == $past(wdata[8:5]) + 5'h1)
        else $error("row width wrong");
    AST_BANK: assert property (wg |=> bank_bits == $past(wdata[4:3]) + 3'h1)
        else $error("bank width wrong");
    AST_DWIDTH: assert property (data_width == 6'h20)
        else $error("data width not 32");
    AST_TRC: assert property (wa |=> t_rc == $past(wdata[25:22]) + 5'h1)
        else $error("t_rc wrong");
    AST_TXSR: assert property (wa |=> t_xsr == {$past(wdata[31:27]), $past(wdata[21:18])} + 10'h1)
        else $error("t_xsr wrong");
    AST_TCMD: assert property (wa |=> t_rcar == $past(wdata[17:14]) + 5'h1
        && t_wr == $past(wdata[13:12]) + 3'h1
        && t_rp == $past(wdata[11:9]) + 4'h1 && t_rcd == $past(wdata[8:6]) + 4'h1
        && t_ras == $past(wdata[5:2]) + 5'h1) else $error("command timing wrong");
    AST_LAT: assert property (wa |=> lat_err == $past(wdata[26])
        && (lat_err || rd_latency == $past(wdata[1:0]) + 3'h1)) else $error("read latency wrong");
    AST_INIT_B: assert property (wb |=> init_refreshes == $past(wdata[19:16]) + 5'h1
        && pwrup_cycles == $past(wdata[15:0])) else $error("init counts wrong");
    AST_INIT_SET: assert property (s_init_set |=> init_req)
        else $error("init not raised");
    AST_INIT_CLR: assert property (clk_en && init_done && !(wc && wdata[0]) |=> !init_req)
        else $error("init not cleared");
    AST_MODE_SET: assert property (s_mode_set |=> mode_upd_req)
        else $error("mode update not raised");
    AST_MODE_CLR: assert property (clk_en && mode_upd_done && !(wc && wdata[9]) |=> !mode_upd_req)
        else $error("mode update not cleared");
    AST_REF_ACK: assert property (clk_en && refresh_ack |=> !refresh_req)
        else $error("refresh request not cleared");
endmodule

bind sct_regs sct_regs_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .init_done(init_done), .mode_upd_done(mode_upd_done),
    .refresh_ack(refresh_ack), .init_req(init_req), .mode_upd_req(mode_upd_req), .refresh_req(refresh_req),
    .col_bits(col_bits), .row_bits(row_bits), .bank_bits(bank_bits), .geom_err(geom_err),
    .data_width(data_width), .t_rc(t_rc), .t_xsr(t_xsr), .t_rcar(t_rcar), .t_wr(t_wr), .t_rp(t_rp),
    .t_rcd(t_rcd), .t_ras(t_ras), .rd_latency(rd_latency), .lat_err(lat_err),
    .init_refreshes(init_refreshes), .pwrup_cycles(pwrup_cycles));

// *** verification/sct_seq_model.sv ***
// behavioural model of the command sequencer that answers the register bank
`timescale 1ns/1ps
module sct_seq_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic init_req,
    input wire logic mode_upd_req,
    input wire logic self_ref_req,
    input wire logic refresh_req,
    output logic init_done,
    output logic mode_upd_done,
    output logic self_ref_active,
    output logic refresh_ack
);
    logic [3:0] wait_q;
    // init and mode update take a short or long while, then done pulses once
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 4'h0;
            init_done <= 1'b0;
            mode_upd_done <= 1'b0;
        end else if ((init_req || mode_upd_req) && !init_done && !mode_upd_done) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == (slow ? 4'hc : 4'h3)) begin
                init_done <= init_req;
                mode_upd_done <= mode_upd_req;
                wait_q <= 4'h0;
            end
        end else begin
            init_done <= 1'b0;
            mode_upd_done <= 1'b0;
        end
    end
    // refresh acked a cycle late, self-refresh entry also follows a cycle late
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            refresh_ack <= 1'b0;
            self_ref_active <= 1'b0;
        end else begin
            refresh_ack <= refresh_req && !refresh_ack;
            self_ref_active <= self_ref_req;
        end
    end
endmodule

// *** verification/tb_sct_regs.sv ***
// self-checking bench for the sdram config register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_sct_regs;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic slow = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata;
    logic init_done, mode_upd_done, self_ref_active, refresh_ack, init_req, mode_upd_req, self_ref_req;
    logic pwr_dn_req, delayed_pre, refresh_req, geom_err, lat_err;
    logic [4:0] col_bits, row_bits, t_rc, t_rcar, t_ras, init_refreshes;
    logic [2:0] bank_bits, t_wr, rd_latency;
    logic [3:0] t_rp, t_rcd;
    logic [5:0] data_width;
    logic [9:0] t_xsr;
    logic [15:0] pwrup_cycles;
    int num_errors = 0;
    int comparisons = 0;
    always #50 ref_clk = ~ref_clk;
    sct_regs dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .init_done(init_done), .mode_upd_done(mode_upd_done),
        .self_ref_active(self_ref_active), .refresh_ack(refresh_ack), .init_req(init_req),
        .mode_upd_req(mode_upd_req), .self_ref_req(self_ref_req), .pwr_dn_req(pwr_dn_req),
        .delayed_pre(delayed_pre), .refresh_req(refresh_req), .col_bits(col_bits), .row_bits(row_bits),
        .bank_bits(bank_bits), .geom_err(geom_err), .data_width(data_width), .t_rc(t_rc), .t_xsr(t_xsr),
        .t_rcar(t_rcar), .t_wr(t_wr), .t_rp(t_rp), .t_rcd(t_rcd), .t_ras(t_ras), .rd_latency(rd_latency),
        .lat_err(lat_err), .init_refreshes(init_refreshes), .pwrup_cycles(pwrup_cycles));
    sct_seq_model u_seq (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .init_req(init_req),
        .mode_upd_req(mode_upd_req), .self_ref_req(self_ref_req), .refresh_req(refresh_req),
        .init_done(init_done), .mode_upd_done(mode_upd_done), .self_ref_active(self_ref_active),
        .refresh_ack(refresh_ack));
    // one-cycle bus write, sampled after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        @(negedge ref_clk);
    endtask
    // one-cycle bus read, data judged in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        `CHK("rdata", ex, rdata)
    endtask
    // waits for the init bit, or the mode bit when mode is set, to self-clear
    task automatic wait_clear(input bit mode);
        for (int i = 0; i < 40 && (mode ? mode_upd_req : init_req) !== 1'b0; i++) @(negedge ref_clk);
    endtask
    // counts cycles up to the next rising refresh request
    task automatic wait_rise(output int n);
        logic prev;
        prev = 1'b1;
        n = 0;
        while (!(prev === 1'b0 && refresh_req === 1'b1) && n < 3000) begin
            prev = refresh_req;
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic t_reset();
        logic [7:0] offs [16] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h54, 8'h58, 8'h5c, 8'h84,
            8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4};
        logic [31:0] rsts [16] = '{32'h1c4f68, 32'h1e5d696, 32'h7008, 32'h410, 32'h0, 32'h5100, 32'h6000, 32'h149,
            32'h249, 32'hc, 32'h50000000, 32'h1154c, 32'h791950, 32'h1c1950, 32'hc8, 32'h1201};
        @(negedge ref_clk);
        `CHK("init_req", 1'b1, init_req)
        `CHK("delayed_pre", 1'b1, delayed_pre)
        rd(8'h0c, 32'h00003009);
        `CHK("col_bits", 5'h08, col_bits)
        `CHK("row_bits", 5'h0c, row_bits)
        `CHK("bank_bits", 3'h2, bank_bits)
        `CHK("t_xsr", 10'h00a, t_xsr)
        `CHK("rd_latency", 3'h3, rd_latency)
        `CHK("pwrup_cycles", 16'h7008, pwrup_cycles)
        wait_clear(1'b0);
        rd(8'h0c, 32'h00003008);
        foreach (offs[i]) rd(offs[i], rsts[i]);
        rd(8'h20, 32'h0);
    endtask
    task automatic t_geom();
        logic [31:0] w;
        for (int i = 0; i < 16; i++) begin
            w = (i << 9) | (i << 5) | ((i & 3) << 3) | ((i & 3) << 13);
            wr(8'h00, w);
            `CHK("col_bits", i[4:0] + 5'h1, col_bits)
            `CHK("row_bits", i[4:0] + 5'h1, row_bits)
            `CHK("bank_bits", {1'b0, i[1:0]} + 3'h1, bank_bits)
            `CHK("geom_err", i < 10 || i == 15, geom_err)
            `CHK("data_width", 6'h20, data_width)
            rd(8'h00, w & 32'h001ffff8);
        end
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(8'h00, 32'h0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rd(8'h00, 32'h7ff8);
    endtask
    task automatic t_tim();
        logic [31:0] p [5] = '{32'h0, 32'hffffffff, 32'h5a5a5a5a, 32'h04000000, 32'h3};
        foreach (p[k]) begin
            wr(8'h04, p[k]);
            `CHK("t_rc", {1'b0, p[k][25:22]} + 5'h1, t_rc)
            `CHK("t_xsr", {p[k][31:27], p[k][21:18]} + 10'h1, t_xsr)
            `CHK("t_rcar", {1'b0, p[k][17:14]} + 5'h1, t_rcar)
            `CHK("t_wr", {1'b0, p[k][13:12]} + 3'h1, t_wr)
            `CHK("t_rp", {1'b0, p[k][11:9]} + 4'h1, t_rp)
            `CHK("t_rcd", {1'b0, p[k][8:6]} + 4'h1, t_rcd)
            `CHK("t_ras", {1'b0, p[k][5:2]} + 5'h1, t_ras)
            `CHK("lat_err", p[k][26], lat_err)
            if (!p[k][26]) `CHK("rd_latency", {1'b0, p[k][1:0]} + 3'h1, rd_latency)
            rd(8'h04, p[k]);
        end
        wr(8'h08, 32'hffffffff);
        `CHK("init_refreshes", 5'h10, init_refreshes)
        `CHK("pwrup_cycles", 16'hffff, pwrup_cycles)
        rd(8'h08, 32'h003fffff);
        wr(8'h08, 32'h0);
        `CHK("init_refreshes", 5'h01, init_refreshes)
    endtask
    task automatic t_ctrl();
        wr(8'h0c, 32'h1);
        `CHK("init_req", 1'b1, init_req)
        wait_clear(1'b0);
        `CHK("init_req", 1'b0, init_req)
        wr(8'h0c, 32'h200);
        `CHK("mode_upd_req", 1'b1, mode_upd_req)
        wait_clear(1'b1);
        `CHK("mode_upd_req", 1'b0, mode_upd_req)
        wr(8'h0c, 32'h0003f1f6);
        `CHK("self_ref_req", 1'b1, self_ref_req)
        `CHK("pwr_dn_req", 1'b1, pwr_dn_req)
        `CHK("delayed_pre", 1'b0, delayed_pre)
        repeat (3) @(negedge ref_clk);
        rd(8'h0c, 32'h0003f9f6);
        wr(8'h0c, 32'h3008);
    endtask
    task automatic t_refresh();
        int n;
        wait_rise(n);
        wait_rise(n);
        `CHK("refresh period", 1040, n)
        wr(8'h10, 32'h20);
        wait_rise(n);
        wait_rise(n);
        `CHK("refresh period", 32, n)
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        slow = 1'b0;
        t_geom();
        t_tim();
        t_ctrl();
        t_refresh();
        tally_and_finish();
    end
    // watchdog against a hung handshake
    initial begin
        #(8000 * 100);
        num_errors++;
        tally_and_finish();
    end
endmodule
